// ---- verilog/disc_pkg.sv ----
// Purpose: Shared constants and types for the input discrepancy monitor
// Assumes: 20 MHz reference clock
// Notes:   Tolerance modes select a time base per input byte
package disc_pkg;
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned SHORT_US      = 1_000;  // About one millisecond
    localparam int unsigned AVERAGE_US    = 5_000;  // About five milliseconds
    localparam int unsigned SHORT_CYCLES  = (CLK_HZ / 1_000_000) * SHORT_US;
    localparam int unsigned AVG_CYCLES    = (CLK_HZ / 1_000_000) * AVERAGE_US;
    localparam int unsigned CNT_W         = 20;
    localparam logic [7:0]  HOLD_RESET    = 8'h00;

    // Tolerance choices per input byte
    typedef enum logic [1:0] {
        TOL_SHORT   = 2'b00,
        TOL_AVERAGE = 2'b01,
        TOL_MAIN    = 2'b10,
        TOL_TIMED   = 2'b11
    } tol_mode_e;

    // Per-byte tolerance setting from the system parameter block
    typedef struct packed {
        tol_mode_e  mode;
        logic [7:0] cycles;
    } tol_cfg_s;

    // Per-byte status
    typedef struct packed {
        logic timing;
        logic failure;
    } byte_stat_s;
endpackage : disc_pkg

// ---- verilog/disc_monitor.sv ----
// Purpose: Compare two subunit readings of input bytes and time mismatches
// Assumes: Readings and cycle strobes are synchronous to ref_clk
// Notes:   Cycle-count tolerances carry one cycle of slack
// Operation
// [RQ1] Compare both subunit readings, every input bit
// [RQ2] Tolerance configurable separately per input byte
// [RQ3] Hold last coinciding value while timing
// [RQ4] Overlong mismatch raises failure and error
// [RQ5] Interrupt inputs: short, average, main cycles
// [RQ6] Bytes 32-33: short, main or timed cycles; the code also accepts average for every non-interrupt byte
// [RQ7] Power restore clears timers, restarts if mismatched
// [RQ8] Cycle counts checked at boundaries, one slack
// [RQ9] Timer starts on mismatch, clears on agreement
`timescale 1ns/1ps

// Per-byte discrepancy tracker.
// Compares both readings of one input byte, times a mismatch against the
// tolerance chosen for this byte, holds the last coinciding value meanwhile
// and latches a failure when the mismatch outlasts the tolerance.
// Limitation: the timer saturates at its limit, so a failure is reported
// once per byte until the next restart, however long the mismatch lasts.
module disc_byte_tracker #(
    parameter int unsigned SHORT_TICKS = disc_pkg::SHORT_CYCLES,
    parameter int unsigned AVG_TICKS   = disc_pkg::AVG_CYCLES
) (
    // Clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_b,
    // Both subunit readings of this byte
    input  wire logic [7:0]    rd_a,
    input  wire logic [7:0]    rd_b,
    // Tolerance setting and cycle boundaries
    input  disc_pkg::tol_cfg_s cfg,
    input  wire logic          irq_byte,
    input  wire logic          main_program_cycle,
    input  wire logic          timed_interrupt_cycle,
    // Results for this byte
    output logic [7:0]         held,
    output logic               timing,
    output logic               failure,
    output logic               fail_new
);
    // Counter width and the fixed limits at that width
    localparam int unsigned   CW        = disc_pkg::CNT_W;
    localparam logic [CW-1:0] SHORT_LIM = CW'(SHORT_TICKS);
    localparam logic [CW-1:0] AVG_LIM   = CW'(AVG_TICKS);
    localparam logic [CW-1:0] CNT_ONE   = CW'(1);

    // Decoded per-cycle conditions
    disc_pkg::tol_mode_e mode_w;
    logic                mismatch;
    logic                tick;
    logic                expired;
    logic [CW-1:0]       limit;

    // Timer, held value and failure latch
    logic [CW-1:0]       cnt_r;
    logic [CW-1:0]       cnt_nxt;
    logic [7:0]          hold_r;
    logic [7:0]          hold_nxt;
    logic                timing_r;
    logic                fail_r;
    logic                fail_nxt;

    // Any differing bit counts; no single bit is trusted on its own
    assign mismatch = (rd_a != rd_b);                                    // RQ1

    // Interrupt bytes have no timed-cycle choice; fall back to main cycles
    assign mode_w = (irq_byte && (cfg.mode == disc_pkg::TOL_TIMED)) ?
                    disc_pkg::TOL_MAIN : cfg.mode;                       // RQ5 RQ6

    // Cycle modes count only at cycle boundaries, so expiry may slip one
    assign tick = (mode_w == disc_pkg::TOL_MAIN)  ? main_program_cycle :
                  (mode_w == disc_pkg::TOL_TIMED) ? timed_interrupt_cycle :
                  1'b1;                                                  // RQ8

    // Fixed times for short and average, configured count otherwise
    assign limit = (mode_w == disc_pkg::TOL_SHORT)   ? SHORT_LIM :
                   (mode_w == disc_pkg::TOL_AVERAGE) ? AVG_LIM :
                   CW'(cfg.cycles);                                      // RQ2

    // Expiry needs a running timer and a mismatch still present
    assign expired = timing_r && mismatch && (cnt_r >= limit);           // RQ4

    // Agreement clears the timer at once; it stops counting at expiry
    assign cnt_nxt = !mismatch          ? '0 :
                     (tick && !expired) ? cnt_r + CNT_ONE :
                     cnt_r;                                              // RQ9

    // Only a coinciding reading passes on; otherwise the last one stands
    assign hold_nxt = mismatch ? hold_r : rd_a;                          // RQ3

    // Failure stays latched until restart
    assign fail_nxt = fail_r | expired;                                  // RQ4

    // Reset stands for power restore: timers restart if still apart
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin                                                // RQ7
            cnt_r    <= '0;
            timing_r <= 1'b0;
            fail_r   <= 1'b0;
            hold_r   <= disc_pkg::HOLD_RESET;
        end else begin
            cnt_r    <= cnt_nxt;
            timing_r <= mismatch;                                        // RQ9
            fail_r   <= fail_nxt;
            hold_r   <= hold_nxt;
        end
    end

    // Results straight from the flip-flops
    assign held     = hold_r;
    assign timing   = timing_r;
    assign failure  = fail_r;
    // A new failure is the first expiry, one cycle before the latch shows it
    assign fail_new = expired && !fail_r;
endmodule : disc_byte_tracker

// Discrepancy monitor for a group of input bytes.
// Each byte has its own tracker and tolerance; the failure of any byte is
// collected into one latched hardware failure and one error pulse.
// Trade-off: the error pulse comes one cycle after the expiry so that it
// is a clean flip-flop output rather than a wide combinational OR.
module disc_monitor #(
    parameter int unsigned NBYTES      = 4,
    parameter int unsigned SHORT_TICKS = disc_pkg::SHORT_CYCLES,
    parameter int unsigned AVG_TICKS   = disc_pkg::AVG_CYCLES,
    parameter logic [NBYTES-1:0] IRQ_BYTE = '0
) (
    // Clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         rst_b,
    // Input readings of both subunits
    input  wire logic [NBYTES-1:0][7:0]       read_a,
    input  wire logic [NBYTES-1:0][7:0]       read_b,
    // Tolerance setting and cycle boundaries
    input  disc_pkg::tol_cfg_s [NBYTES-1:0]   tol_cfg,
    input  wire logic                         main_program_cycle,
    input  wire logic                         timed_interrupt_cycle,
    // Results to the user program
    output logic [NBYTES-1:0][7:0]            input_byte,
    output disc_pkg::byte_stat_s [NBYTES-1:0] stat,
    output logic                              hw_failure,
    output logic                              error_pulse
);
    // Per-byte results; unpacked so each tracker drives its own element
    logic [7:0] held_w     [NBYTES];
    logic       timing_w   [NBYTES];
    logic       failure_w  [NBYTES];
    logic       fail_new_w [NBYTES];
    logic       fail_any_new;

    // Collected failure and error pulse
    logic       fail_any_r;
    logic       fail_any_nxt;
    logic       err_r;
    logic       err_nxt;

    // One tracker per input byte, each with its own tolerance
    for (genvar g = 0; g < NBYTES; g++) begin : gen_byte
        disc_byte_tracker #(
            .SHORT_TICKS (SHORT_TICKS),
            .AVG_TICKS   (AVG_TICKS)
        ) u_trk (
            .ref_clk               (ref_clk),
            .rst_b                 (rst_b),
            .rd_a                  (read_a[g]),
            .rd_b                  (read_b[g]),
            .cfg                   (tol_cfg[g]),                         // RQ2
            .irq_byte              (IRQ_BYTE[g]),                        // RQ5
            .main_program_cycle    (main_program_cycle),
            .timed_interrupt_cycle (timed_interrupt_cycle),
            .held                  (held_w[g]),
            .timing                (timing_w[g]),
            .failure               (failure_w[g]),
            .fail_new              (fail_new_w[g])
        );
    end

    // Gather per-byte results into the packed outputs
    always_comb begin
        fail_any_new = 1'b0;
        for (int i = 0; i < NBYTES; i++) begin
            input_byte[i]   = held_w[i];                                 // RQ3
            stat[i].timing  = timing_w[i];
            stat[i].failure = failure_w[i];
            fail_any_new    = fail_any_new | fail_new_w[i];
        end
    end

    // A new failure wins over holding; the latch never clears before reset
    assign fail_any_nxt = fail_any_r | fail_any_new;                     // RQ4
    assign err_nxt      = fail_any_new;                                  // RQ4

    // Failure is latched until reset; error is high the cycle after each cycle with a new failure
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            fail_any_r <= 1'b0;
            err_r      <= 1'b0;
        end else begin
            fail_any_r <= fail_any_nxt;
            err_r      <= err_nxt;
        end
    end

    // Both from flip-flops, safe to use anywhere
    assign hw_failure  = fail_any_r;
    assign error_pulse = err_r;
endmodule : disc_monitor

// ---- bench/disc_monitor_monitor.sv ----
// Purpose: Port checks for disc_monitor, byte 0
// Assumes: A few clocks of latency
// Notes:   Bound at the foot
`timescale 1ns/1ps
module disc_monitor_monitor #(parameter int unsigned NBYTES = 4, SHORT_TICKS = 20) (
    input wire logic ref_clk, rst_b, main_program_cycle, timed_interrupt_cycle,
    input wire logic hw_failure, error_pulse,
    input wire logic [NBYTES-1:0][7:0] read_a, read_b, input_byte,
    input disc_pkg::tol_cfg_s [NBYTES-1:0] tol_cfg,
    input disc_pkg::byte_stat_s [NBYTES-1:0] stat);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    localparam int LIM = SHORT_TICKS + 6;
    // Slack on expiry: tolerance is approximate
    wire agree = read_a[0] == read_b[0];
    wire t = stat[0].timing, f = stat[0].failure;
    wire shrt = tol_cfg[0].mode == disc_pkg::TOL_SHORT;
    a_agree_pass: assert property ((agree && $stable(read_a[0]))[*3] |-> input_byte[0] == read_a[0])
        else $error("agreed value not passed");
    a_hold_last: assert property (t && $past(t) && !f |-> $stable(input_byte[0]))
        else $error("held value moved");
    a_mismatch_timed: assert property ((!agree)[*3] |-> t || f) else $error("no timing");
    a_agree_clears: assert property (agree[*3] && !f |-> !t) else $error("timer stuck");
    a_short_early: assert property ($rose(t) && shrt |-> (!f)[*8]) else $error("early fail");
    a_short_expiry: assert property ($rose(t) && shrt |-> ##[1:LIM] (f || !t))
        else $error("late fail");
    a_fail_flag: assert property (f |-> ##[0:2] hw_failure) else $error("no failure");
    a_err_cause: assert property (error_pulse |-> ##[0:2] hw_failure) else $error("stray error");
    c_fail: cover property ($rose(f));
    c_clear: cover property ($fell(t) && !f);
    c_main: cover property (t && tol_cfg[0].mode == disc_pkg::TOL_MAIN);
endmodule : disc_monitor_monitor
bind disc_monitor disc_monitor_monitor #(.NBYTES(NBYTES), .SHORT_TICKS(SHORT_TICKS)) mon_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .main_program_cycle(main_program_cycle),
    .timed_interrupt_cycle(timed_interrupt_cycle), .hw_failure(hw_failure), .stat(stat),
    .error_pulse(error_pulse), .read_a(read_a), .read_b(read_b), .input_byte(input_byte),
    .tol_cfg(tol_cfg));

// ---- bench/subunit_model.sv ----
// Purpose: Second subunit reading the same sensors
// Assumes: Fault flag set by the bench
// Notes:   One clock later than the first read, so changes skew
`timescale 1ns/1ps
module subunit_model (input wire logic ref_clk, input wire logic [7:0] sensor,
    input wire logic fault, output logic [7:0] read_b);
    // A faulty channel reads the inverse
    always_ff @(posedge ref_clk) begin
        read_b <= fault ? ~sensor : sensor;
    end
endmodule : subunit_model

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for disc_monitor
// Assumes: Tolerances shortened by parameters
// Notes:   Row i: mode i/2, fails when i odd
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 0, rst_b = 0, main_c = 0, timed_c = 0, fault = 0, hw, err;
    logic [7:0] sensor = 8'h5A;
    wire logic [1:0][7:0] rb;
    logic [1:0][7:0] ib;
    disc_pkg::tol_cfg_s [1:0] cfg = {{disc_pkg::TOL_TIMED, 8'h02}, {disc_pkg::TOL_SHORT, 8'h02}};
    disc_pkg::byte_stat_s [1:0] st;
    int error_cnt = 0, n_checks = 0, cyc = 0, n_err = 0;
    int len[8] = '{10, 40, 30, 100, 6, 50, 6, 50};
    assign rb[1] = 8'h3C;
    disc_monitor #(.NBYTES(2), .SHORT_TICKS(20), .AVG_TICKS(60)) disc_monitor_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .read_a({8'h3C, sensor}), .read_b(rb), .tol_cfg(cfg),
        .main_program_cycle(main_c), .timed_interrupt_cycle(timed_c), .input_byte(ib),
        .stat(st), .hw_failure(hw), .error_pulse(err));
    subunit_model subunit_model_inst (.ref_clk(ref_clk), .sensor(sensor), .fault(fault),
        .read_b(rb[0]));
    always #25 ref_clk = ~ref_clk;
    // Cycle strobes every 8 clocks; hang guard
    always @(posedge ref_clk) #1 begin
        cyc++;
        n_err += err;
        main_c = cyc % 8 == 0;
        timed_c = cyc % 8 == 4;
        if (cyc > 9000) begin error_cnt++; give_verdict(); end
    end
    task tick(int n); repeat (n) @(posedge ref_clk); #1; endtask : tick
    task chk(logic c, string s);
        n_checks++;
        if (!c) begin error_cnt++; $display("BAD %0t %s", $time, s); end
    endtask : chk
    task give_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        tick(20);
        foreach (len[i]) begin
            rst_b = 0; n_err = 0; cfg[0].mode = disc_pkg::tol_mode_e'(i / 2); tick(3);
            rst_b = 1; tick(6);
            fault = 1; tick(3);
            chk(ib[0] === 8'h5A, "held value lost");
            tick(len[i]); chk(st[0].failure === i[0] && hw === i[0], "failure flag");
            chk(st[1].failure === 1'b0, "other byte failed");
            chk(n_err == int'(i[0]), "error pulse count");
            fault = 0; tick(4); if (!i[0]) chk(st[0].timing === 1'b0, "timer stuck");
        end
        rst_b = 0; cfg[0].mode = disc_pkg::TOL_SHORT; tick(3); rst_b = 1; sensor = 8'hC3; tick(6);
        chk(ib[0] === 8'hC3, "agreed value");
        fault = 1; tick(12); rst_b = 0; tick(2); rst_b = 1; tick(12);
        chk(st[0].failure === 1'b0, "timer kept over restart");
        tick(30); chk(st[0].failure === 1'b1, "no restart");
        give_verdict();
    end
endmodule : testbench
